// *** hw/pmp_defines.svh ***
`ifndef PMP_DEFINES_SVH
`define PMP_DEFINES_SVH
`define MODE_LEGACY 2'h0
`define MODE_ADDRESSED 2'h1
`define MODE_MST_SEP 2'h2
`define MODE_MST_COMB 2'h3
`define INCR_BUFFERED 2'h3
`define IRQ_EVERY 2'h1
`define IRQ_BUF3 2'h3
`define MUX_NONE 2'h0
`define MUX_PART 2'h1
`define MUX_FULL 2'h2
`define LAST_BUF 2'h3
`define EMPTY_RST 4'hF
`define FULL_RST 4'h0
`define STROBE_LAST 2'h2
`define REQ_W 17
`endif

// *** hw/pmp_pkg.sv ***
package pmp_pkg;
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_ALL = 3'b001,
        M_ALH = 3'b010,
        M_DATA = 3'b011
    } mst_state_t;
endpackage

// *** hw/parallel_master_slave_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pmp_defines.svh"

module pmp_req_fifo #(
    parameter int W = 17,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    generate
        if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_bad_depth
            $error("FIFO depth must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic in_rdy;
        logic out_vld;
    } fifo_st_t;

    fifo_st_t st_ff;
    fifo_st_t nxt_st;
    logic push;
    logic pop;

    always_comb begin
        nxt_st = st_ff;
        push = in_valid_in & st_ff.in_rdy;
        pop = st_ff.out_vld & out_ready_in;
        if (push) begin
            nxt_st.mem[st_ff.wp] = in_data_in;
            nxt_st.wp = st_ff.wp + PW'(1);
        end
        if (pop) begin
            nxt_st.rp = st_ff.rp + PW'(1);
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + (PW+1)'(1);
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - (PW+1)'(1);
        end
        nxt_st.in_rdy = (nxt_st.cnt != (PW+1)'(DEPTH));
        nxt_st.out_vld = (nxt_st.cnt != '0);
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_ff <= '{mem: '0, wp: '0, rp: '0, cnt: '0, in_rdy: 1'b1, out_vld: 1'b0};
        end else if (clk_en_in) begin
            st_ff <= nxt_st;
        end
    end

    assign in_ready_out = st_ff.in_rdy;
    assign out_valid_out = st_ff.out_vld;
    assign out_data_out = st_ff.mem[st_ff.rp];
endmodule // pmp_req_fifo

////////////////////////////////////////////////////////////////////////////////

module parallel_master_slave_port #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic port_enable_bit_in,
    input wire logic [1:0] mode_field_in,
    input wire logic [1:0] buffer_incr_field_in,
    input wire logic [1:0] irq_mode_field_in,
    input wire logic wide_data_bit_in,
    input wire logic [1:0] addr_mux_field_in,
    input wire logic [1:0] cs_config_in,
    input wire logic byte_en_pin_enable_in,
    input wire logic write_pin_enable_in,
    input wire logic read_pin_enable_in,
    input wire logic [15:0] addr_pin_enable_in,
    input wire logic pol_read_in,
    input wire logic pol_write_in,
    input wire logic pol_byte_en_in,
    input wire logic pol_latch_in,
    input wire logic pol_cs_one_in,
    input wire logic pol_cs_two_in,
    input wire logic [15:0] master_addr_reg_in,
    input wire logic sw_out_wr_in,
    input wire logic [1:0] sw_out_idx_in,
    input wire logic [7:0] sw_out_data_in,
    input wire logic sw_in_rd_in,
    input wire logic [1:0] sw_in_idx_in,
    input wire logic clr_underflow_in,
    input wire logic clr_overflow_in,
    input wire logic clr_irq_in,
    input wire logic mst_req_valid_in,
    input wire logic mst_req_write_in,
    input wire logic [15:0] mst_req_data_in,
    output logic mst_req_ready_out,
    output logic mst_done_out,
    output logic [15:0] mst_rd_data_out,
    input wire logic port_chip_sel_in,
    input wire logic port_read_strobe_in,
    input wire logic port_write_strobe_in,
    input wire logic [1:0] slave_addr_lines_in,
    input wire logic [7:0] port_data_bus_in,
    output logic [7:0] port_data_bus_out,
    output logic port_data_bus_oe_out,
    output logic read_pin_out,
    output logic read_pin_oe_out,
    output logic write_pin_out,
    output logic write_pin_oe_out,
    output logic byte_enable_strobe_out,
    output logic byte_enable_oe_out,
    output logic [15:0] addr_pins_out,
    output logic [15:0] addr_pins_oe_out,
    output logic [3:0] out_empty_flags_out,
    output logic out_all_empty_out,
    output logic out_underflow_out,
    output logic [3:0] in_full_flags_out,
    output logic in_all_full_out,
    output logic in_overflow_out,
    output logic port_irq_flag_out,
    output logic [31:0] in_buf_data_out
);
    typedef struct packed {
        logic cs_s1, cs_s2, rd_s1, rd_s2, wr_s1, wr_s2;
        logic [1:0] a_s1, a_s2;
        logic [7:0] d_s1, d_s2;
        logic rd_prev, wr_prev;
        logic [1:0] rd_idx, wr_idx, rd_ptr, wr_ptr;
        logic [7:0] wr_data;
        logic [3:0][7:0] in_buf, out_buf;
        logic [3:0] out_empty, in_full;
        logic all_empty, underflow, all_full, overflow, irq;
        pmp_pkg::mst_state_t mst;
        logic [1:0] cnt;
        logic second;
        logic [`REQ_W-1:0] req;
        logic [15:0] rd_data;
        logic done;
        logic [7:0] bus;
        logic bus_oe, rd_pin, rd_oe, wr_pin, wr_oe, be_pin, be_oe;
        logic [15:0] apin, apin_oe;
    } port_st_t;

    port_st_t st_ff;
    port_st_t nxt_st;
    logic fifo_vld;
    logic fifo_pop;
    logic [`REQ_W-1:0] fifo_data;
    logic slave_on, mst_on, legacy, buffered, addressed;
    logic rd_act, wr_act, rd_start, rd_end, wr_start, wr_end;
    logic in_addr, in_data, busy, wr_dir;
    logic [1:0] sel;

    function automatic logic lvl(input logic pol, input logic act);
        return pol ? act : ~act;
    endfunction

    pmp_req_fifo #(.W(`REQ_W), .DEPTH(FIFO_DEPTH)) u_req_fifo (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .in_valid_in(mst_req_valid_in),
        .in_ready_out(mst_req_ready_out),
        .in_data_in({mst_req_write_in, mst_req_data_in}),
        .out_valid_out(fifo_vld),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        nxt_st = st_ff;
        nxt_st.cs_s1 = port_chip_sel_in;
        nxt_st.cs_s2 = st_ff.cs_s1;
        nxt_st.rd_s1 = port_read_strobe_in;
        nxt_st.rd_s2 = st_ff.rd_s1;
        nxt_st.wr_s1 = port_write_strobe_in;
        nxt_st.wr_s2 = st_ff.wr_s1;
        nxt_st.a_s1 = slave_addr_lines_in;
        nxt_st.a_s2 = st_ff.a_s1;
        nxt_st.d_s1 = port_data_bus_in;
        nxt_st.d_s2 = st_ff.d_s1;

        slave_on = port_enable_bit_in & ~mode_field_in[1];
        mst_on = port_enable_bit_in & mode_field_in[1];
        addressed = slave_on & (mode_field_in == `MODE_ADDRESSED);
        buffered = slave_on & (mode_field_in == `MODE_LEGACY) & (buffer_incr_field_in == `INCR_BUFFERED);
        legacy = slave_on & ~addressed & ~buffered;
        rd_act = slave_on & st_ff.cs_s2 & st_ff.rd_s2;
        wr_act = slave_on & st_ff.cs_s2 & st_ff.wr_s2;
        rd_start = rd_act & ~st_ff.rd_prev;
        rd_end = ~rd_act & st_ff.rd_prev;
        wr_start = wr_act & ~st_ff.wr_prev;
        wr_end = ~wr_act & st_ff.wr_prev;
        nxt_st.rd_prev = rd_act;
        nxt_st.wr_prev = wr_act;
        nxt_st.done = 1'b0;

        // Software side clears first so that a hardware set in the same cycle wins
        if (sw_out_wr_in) begin
            nxt_st.out_buf[sw_out_idx_in] = sw_out_data_in;
            nxt_st.out_empty[sw_out_idx_in] = 1'b0;
        end
        if (sw_in_rd_in) begin
            nxt_st.in_full[sw_in_idx_in] = 1'b0;
        end
        if (clr_underflow_in) begin
            nxt_st.underflow = 1'b0;
        end
        if (clr_overflow_in) begin
            nxt_st.overflow = 1'b0;
        end
        if (clr_irq_in) begin
            nxt_st.irq = 1'b0;
        end

        // Buffer select: 0 in legacy, pointer when buffered, address lines when addressed
        if (addressed) begin
            sel = st_ff.a_s2;
        end else if (buffered) begin
            sel = rd_start ? st_ff.rd_ptr : st_ff.wr_ptr;
        end else begin
            sel = 2'h0;
        end
        if (rd_start) begin
            nxt_st.rd_idx = sel;
        end
        if (wr_start) begin
            nxt_st.wr_idx = addressed ? st_ff.a_s2 : (buffered ? st_ff.wr_ptr : 2'h0);
        end
        if (wr_act) begin
            nxt_st.wr_data = st_ff.d_s2;
        end

        if (rd_end && !legacy) begin
            if (st_ff.out_empty[st_ff.rd_idx]) begin
                nxt_st.underflow = 1'b1;
            end
            nxt_st.out_empty[st_ff.rd_idx] = 1'b1;
            if (buffered) begin
                nxt_st.rd_ptr = st_ff.rd_ptr + 2'h1;
            end
            if ((irq_mode_field_in == `IRQ_EVERY) ||
                ((irq_mode_field_in == `IRQ_BUF3) && (st_ff.rd_idx == `LAST_BUF))) begin
                nxt_st.irq = 1'b1;
            end
        end

        if (wr_end) begin
            if (st_ff.in_full[st_ff.wr_idx]) begin
                nxt_st.overflow = 1'b1;
            end else begin
                nxt_st.in_buf[st_ff.wr_idx] = st_ff.wr_data;
                nxt_st.in_full[st_ff.wr_idx] = 1'b1;
            end
            if (buffered) begin
                nxt_st.wr_ptr = st_ff.wr_ptr + 2'h1;
            end
            if (legacy || (irq_mode_field_in == `IRQ_EVERY) ||
                ((irq_mode_field_in == `IRQ_BUF3) && (st_ff.wr_idx == `LAST_BUF))) begin
                nxt_st.irq = 1'b1;
            end
        end
        if (!slave_on) begin
            nxt_st.rd_ptr = 2'h0;
            nxt_st.wr_ptr = 2'h0;
        end
        nxt_st.all_empty = &nxt_st.out_empty;
        nxt_st.all_full = &nxt_st.in_full;

        // Master sequencer
        fifo_pop = mst_on & (st_ff.mst == pmp_pkg::M_IDLE);
        case (st_ff.mst)
            pmp_pkg::M_IDLE: begin
                if (fifo_pop && fifo_vld) begin
                    nxt_st.req = fifo_data;
                    nxt_st.second = 1'b0;
                    nxt_st.cnt = 2'h0;
                    if (addr_mux_field_in == `MUX_NONE) begin
                        nxt_st.mst = pmp_pkg::M_DATA;
                    end else begin
                        nxt_st.mst = pmp_pkg::M_ALL;
                    end
                end
            end
            pmp_pkg::M_ALL: begin
                nxt_st.mst = (addr_mux_field_in == `MUX_FULL) ? pmp_pkg::M_ALH : pmp_pkg::M_DATA;
            end
            pmp_pkg::M_ALH: begin
                nxt_st.mst = pmp_pkg::M_DATA;
            end
            pmp_pkg::M_DATA: begin
                nxt_st.cnt = st_ff.cnt + 2'h1;
                if (st_ff.cnt == `STROBE_LAST) begin
                    nxt_st.cnt = 2'h0;
                    if (st_ff.second) begin
                        nxt_st.rd_data[15:8] = st_ff.d_s2;
                    end else begin
                        nxt_st.rd_data[7:0] = st_ff.d_s2;
                    end
                    if (wide_data_bit_in && !st_ff.second) begin
                        nxt_st.second = 1'b1;
                    end else begin
                        nxt_st.mst = pmp_pkg::M_IDLE;
                        nxt_st.done = 1'b1;
                    end
                end
            end
            default: begin
                nxt_st.mst = pmp_pkg::M_IDLE;
            end
        endcase
        if (!mst_on) begin
            nxt_st.mst = pmp_pkg::M_IDLE;
        end

        // Pin levels follow the next state so every pin comes from a flop
        in_addr = (nxt_st.mst == pmp_pkg::M_ALL) || (nxt_st.mst == pmp_pkg::M_ALH);
        in_data = (nxt_st.mst == pmp_pkg::M_DATA);
        busy = (nxt_st.mst != pmp_pkg::M_IDLE);
        wr_dir = nxt_st.req[16];
        if (mode_field_in == `MODE_MST_COMB) begin
            nxt_st.rd_pin = lvl(pol_read_in, busy & ~wr_dir);
            nxt_st.wr_pin = lvl(pol_write_in, in_data);
        end else begin
            nxt_st.rd_pin = lvl(pol_read_in, in_data & ~wr_dir);
            nxt_st.wr_pin = lvl(pol_write_in, in_data & wr_dir);
        end
        nxt_st.be_pin = lvl(pol_byte_en_in, in_data & nxt_st.second);
        nxt_st.rd_oe = mst_on & read_pin_enable_in;
        nxt_st.wr_oe = mst_on & write_pin_enable_in;
        nxt_st.be_oe = mst_on & byte_en_pin_enable_in;
        nxt_st.apin = master_addr_reg_in;
        if (cs_config_in[1]) begin
            nxt_st.apin[15] = lvl(pol_cs_two_in, master_addr_reg_in[15] & busy);
        end
        if (cs_config_in[0]) begin
            nxt_st.apin[14] = lvl(pol_cs_one_in, master_addr_reg_in[14] & busy);
        end
        if (addr_mux_field_in != `MUX_NONE) begin
            nxt_st.apin[0] = lvl(pol_latch_in, nxt_st.mst == pmp_pkg::M_ALL);
        end
        if (addr_mux_field_in == `MUX_FULL) begin
            nxt_st.apin[1] = lvl(pol_latch_in, nxt_st.mst == pmp_pkg::M_ALH);
        end
        nxt_st.apin_oe = mst_on ? addr_pin_enable_in : 16'h0000;

        if (mst_on) begin
            nxt_st.bus_oe = in_addr | (in_data & wr_dir);
            if (nxt_st.mst == pmp_pkg::M_ALL) begin
                nxt_st.bus = master_addr_reg_in[7:0];
            end else if (nxt_st.mst == pmp_pkg::M_ALH) begin
                nxt_st.bus = nxt_st.apin[15:8];
            end else begin
                nxt_st.bus = nxt_st.second ? nxt_st.req[15:8] : nxt_st.req[7:0];
            end
        end else begin
            nxt_st.bus_oe = rd_act;
            nxt_st.bus = nxt_st.out_buf[nxt_st.rd_idx];
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_ff <= '{out_empty: `EMPTY_RST, in_full: `FULL_RST, all_empty: 1'b1,
                       mst: pmp_pkg::M_IDLE, default: '0};
        end else if (clk_en_in) begin
            st_ff <= nxt_st;
        end
    end

    assign mst_done_out = st_ff.done;
    assign mst_rd_data_out = st_ff.rd_data;
    assign port_data_bus_out = st_ff.bus;
    assign port_data_bus_oe_out = st_ff.bus_oe;
    assign read_pin_out = st_ff.rd_pin;
    assign read_pin_oe_out = st_ff.rd_oe;
    assign write_pin_out = st_ff.wr_pin;
    assign write_pin_oe_out = st_ff.wr_oe;
    assign byte_enable_strobe_out = st_ff.be_pin;
    assign byte_enable_oe_out = st_ff.be_oe;
    assign addr_pins_out = st_ff.apin;
    assign addr_pins_oe_out = st_ff.apin_oe;
    assign out_empty_flags_out = st_ff.out_empty;
    assign out_all_empty_out = st_ff.all_empty;
    assign out_underflow_out = st_ff.underflow;
    assign in_full_flags_out = st_ff.in_full;
    assign in_all_full_out = st_ff.all_full;
    assign in_overflow_out = st_ff.overflow;
    assign port_irq_flag_out = st_ff.irq;
    assign in_buf_data_out = st_ff.in_buf;

    ////////////////////////////////////////////////////////////////////////////////

    logic [1:0] chk_wr_idx;
    assign chk_wr_idx = st_ff.wr_idx;

    property p_slave_read_drive;
        @(posedge sys_clk_in) disable iff (reset_in || !clk_en_in)
        rd_act |=> port_data_bus_oe_out;
    endproperty
    a_slave_read_drive: assert property (p_slave_read_drive) else $error("slave read not driven");

    property p_all_empty;
        @(posedge sys_clk_in) disable iff (reset_in)
        out_all_empty_out == (&out_empty_flags_out);
    endproperty
    a_all_empty: assert property (p_all_empty) else $error("all-empty mismatch");

    property p_all_full;
        @(posedge sys_clk_in) disable iff (reset_in)
        in_all_full_out == (&in_full_flags_out);
    endproperty
    a_all_full: assert property (p_all_full) else $error("all-full mismatch");

    property p_underflow;
        @(posedge sys_clk_in) disable iff (reset_in || !clk_en_in)
        (rd_end && !legacy && st_ff.out_empty[st_ff.rd_idx]) |=> out_underflow_out;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow not raised");

    property p_overflow_drop;
        @(posedge sys_clk_in) disable iff (reset_in || !clk_en_in)
        (wr_end && st_ff.in_full[st_ff.wr_idx]) |=> in_overflow_out && $stable(in_buf_data_out);
    endproperty
    a_overflow_drop: assert property (p_overflow_drop) else $error("overflow byte not dropped");

    property p_full_set;
        @(posedge sys_clk_in) disable iff (reset_in || !clk_en_in)
        (wr_end && !st_ff.in_full[st_ff.wr_idx]) |=> in_full_flags_out[$past(chk_wr_idx)];
    endproperty
    a_full_set: assert property (p_full_set) else $error("full flag not set");

    property p_sticky;
        @(posedge sys_clk_in) disable iff (reset_in || !clk_en_in)
        (out_underflow_out && !clr_underflow_in) |=> out_underflow_out;
    endproperty
    a_sticky: assert property (p_sticky) else $error("underflow lost");

    property p_master_only;
        @(posedge sys_clk_in) disable iff (reset_in || !clk_en_in)
        !(port_enable_bit_in && mode_field_in[1]) |=> addr_pins_oe_out == 16'h0000 && !read_pin_oe_out;
    endproperty
    a_master_only: assert property (p_master_only) else $error("master pins while not master");

    property p_full_mux;
        @(posedge sys_clk_in) disable iff (reset_in || !clk_en_in || !mst_on)
        (st_ff.mst == pmp_pkg::M_IDLE && fifo_vld && addr_mux_field_in == `MUX_FULL)
        |=> st_ff.mst == pmp_pkg::M_ALL ##1 st_ff.mst == pmp_pkg::M_ALH ##1 st_ff.mst == pmp_pkg::M_DATA;
    endproperty
    a_full_mux: assert property (p_full_mux) else $error("address phases out of order");

    property p_wide_second;
        @(posedge sys_clk_in) disable iff (reset_in || !clk_en_in || !mst_on)
        (st_ff.mst == pmp_pkg::M_DATA && !st_ff.second && wide_data_bit_in && st_ff.cnt == `STROBE_LAST)
        |=> st_ff.second && st_ff.mst == pmp_pkg::M_DATA;
    endproperty
    a_wide_second: assert property (p_wide_second) else $error("high byte cycle missing");
endmodule // parallel_master_slave_port

`default_nettype wire

// *** tb/ext_proc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_proc (
    input wire logic clk_in,
    output logic cs_out,
    output logic rd_out,
    output logic wr_out,
    output logic [1:0] addr_out,
    output logic [7:0] data_out,
    input wire logic [7:0] bus_in
);
    initial begin
        cs_out = 1'b0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 2'h0;
        data_out = 8'hA5;
    end
    // Strobe held 6 clocks so the synchronised strobe spans the data window
    task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        cs_out <= 1'b1;
        rd_out <= !w;
        wr_out <= w;
        addr_out <= a;
        data_out <= w ? d : ~data_out;
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        q = bus_in;
        @(posedge clk_in);
        cs_out <= 1'b0;
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        data_out <= ~data_out;
        repeat (6) @(posedge clk_in);
    endtask
endmodule // ext_proc
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic clr = 1'b0;
    logic [1:0] idx = 2'h0;
    logic [1:0] mode = 2'h0;
    logic [7:0] swd = 8'h00;
    logic cs, rs, ws, uf, ov, ae, af, irq;
    logic [1:0] pa;
    logic [7:0] pd, dbo, q;
    logic [3:0] ef, ff;
    logic [31:0] ibd;
    logic [7:0] e [4];
    logic en = 1'b1;
    logic mv = 1'b0;
    logic [1:0] incr = 2'h3;
    logic [1:0] irq_mode_field = 2'h1;
    logic [47:0] cfg = '0;
    logic rdy, dn, boe, rpoe, wpoe, bpoe;
    logic [15:0] apoe, mrd;
    int fail_count = 0;
    int samples_checked = 0;
    initial forever #5 clk = ~clk;
    ext_proc proc (.clk_in(clk), .cs_out(cs), .rd_out(rs), .wr_out(ws), .addr_out(pa), .data_out(pd), .bus_in(dbo));
    parallel_master_slave_port dut (.sys_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1), .port_enable_bit_in(en),
        .mode_field_in(mode), .buffer_incr_field_in(incr), .irq_mode_field_in(irq_mode_field), .wide_data_bit_in(cfg[0]),
        .addr_mux_field_in(cfg[2:1]), .cs_config_in(cfg[4:3]), .byte_en_pin_enable_in(cfg[5]),
        .write_pin_enable_in(cfg[6]), .read_pin_enable_in(cfg[7]), .addr_pin_enable_in(cfg[23:8]),
        .pol_read_in(cfg[24]), .pol_write_in(cfg[25]), .pol_byte_en_in(cfg[26]), .pol_latch_in(cfg[27]),
        .pol_cs_one_in(cfg[28]), .pol_cs_two_in(cfg[29]), .master_addr_reg_in(cfg[45:30]),
        .sw_out_wr_in(sw_wr), .sw_out_idx_in(idx), .sw_out_data_in(swd), .sw_in_rd_in(sw_rd),
        .sw_in_idx_in(idx), .clr_underflow_in(clr), .clr_overflow_in(clr), .clr_irq_in(clr),
        .mst_req_valid_in(mv), .mst_req_write_in(1'b0), .mst_req_data_in(16'h0000), .mst_req_ready_out(rdy),
        .mst_done_out(dn), .mst_rd_data_out(mrd), .port_chip_sel_in(cs), .port_read_strobe_in(rs),
        .port_write_strobe_in(ws), .slave_addr_lines_in(pa), .port_data_bus_in(pd), .port_data_bus_out(dbo),
        .port_data_bus_oe_out(boe), .read_pin_out(), .read_pin_oe_out(rpoe), .write_pin_out(),
        .write_pin_oe_out(wpoe), .byte_enable_strobe_out(), .byte_enable_oe_out(bpoe), .addr_pins_out(),
        .addr_pins_oe_out(apoe),
        .out_empty_flags_out(ef), .out_all_empty_out(ae), .out_underflow_out(uf), .in_full_flags_out(ff),
        .in_all_full_out(af), .in_overflow_out(ov), .port_irq_flag_out(irq), .in_buf_data_out(ibd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Master read: low byte first, high byte only in wide mode, both from the far side's bus
    function automatic logic [15:0] exp_rd(input logic wide, input logic [7:0] b);
        return {wide ? b : 8'h00, b};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Software side: one-cycle load of an output buffer or read of an input buffer
    task automatic sw(input logic w, input logic [1:0] i, input logic [7:0] d);
        @(posedge clk);
        sw_wr <= w;
        sw_rd <= !w;
        idx <= i;
        swd <= d;
        @(posedge clk);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        @(negedge clk);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        $display("watchdog expired");
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(81552));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cfg <= 48'({$urandom, $urandom});
        @(negedge clk);
        chk(ae, 32'h1, "all empty at reset");
        for (int i = 0; i < 4; i++) begin
            e[i] = 8'($urandom);
            sw(1'b1, 2'(i), e[i]);
            chk(ef, 32'(4'(4'hF << (i + 1))), "empty flags on load");
        end
        chk(ae, 32'h0, "all empty loaded");
        for (int i = 0; i < 4; i++) begin
            proc.access(1'b0, 2'h3, 8'h00, q);
            chk(q, e[i], "buffered read");
        end
        chk({uf, ae, ef}, 32'h1F, "empty after reads");
        proc.access(1'b0, 2'h0, 8'h00, q);
        chk(uf, 32'h1, "underflow");
        repeat (20) @(posedge clk);
        chk(uf, 32'h1, "underflow held");
        $display("test buffered read done");
        for (int i = 0; i < 4; i++) begin
            e[i] = 8'($urandom);
            proc.access(1'b1, 2'h2, e[i], q);
            chk(ff, 32'((1 << (i + 1)) - 1), "full flags");
        end
        chk(ibd, {e[3], e[2], e[1], e[0]}, "input buffers");
        chk({af, irq, ov}, 32'h6, "all full and irq");
        proc.access(1'b1, 2'h0, ~e[0], q);
        chk({ov, ibd[7:0]}, {1'b1, e[0]}, "overflow drops byte");
        sw(1'b0, 2'h0, 8'h00);
        chk({af, ff}, 32'hE, "software read clears full");
        $display("test buffered write done");
        @(posedge clk);
        mode <= 2'h1;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        e[2] = 8'($urandom);
        sw(1'b1, 2'h2, e[2]);
        proc.access(1'b0, 2'h2, 8'h00, q);
        chk({q, ef, uf}, {e[2], 5'h1E}, "addressed read");
        proc.access(1'b0, 2'h2, 8'h00, q);
        chk(uf, 32'h1, "addressed underflow");
        sw(1'b0, 2'h1, 8'h00);
        e[1] = 8'($urandom);
        proc.access(1'b1, 2'h1, e[1], q);
        chk({ff, ibd[15:8], ov}, {4'hE, e[1], 1'b0}, "addressed write");
        proc.access(1'b1, 2'h1, ~e[1], q);
        chk({ov, ibd[15:8]}, {1'b1, e[1]}, "addressed overflow");
        $display("test addressed done");
        @(posedge clk);
        mode <= 2'h2;
        mv <= 1'b1;
        @(posedge clk);
        mv <= 1'b0;
        repeat (20) if (dn !== 1'b1) @(negedge clk);
        chk({dn, mrd}, {1'b1, exp_rd(cfg[0], pd)}, "master read data");
        chk({rdy, boe, bpoe, wpoe, rpoe, apoe},
            {1'b1, 1'b0, cfg[5], cfg[6], cfg[7], cfg[23:8]}, "master pins");
        $display("test master done");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
